// ---- ccp_compare_pkg.sv ----
// Purpose: constants and types for the compare unit
// Assumes: one 200 MHz clock, timer ticks arrive as pins
// Notes: control bits are plain ports, no register bus
package ccp_compare_pkg;
	localparam int VALUE_W = 16;
	localparam int MODE_W = 4;
	localparam int SYNC_W = 3;
	localparam logic [MODE_W-1:0] MODE_OFF = 4'h0;
	localparam logic [MODE_W-1:0] MODE_TOGGLE = 4'h2;
	localparam logic [MODE_W-1:0] MODE_SET = 4'h8;
	localparam logic [MODE_W-1:0] MODE_CLEAR = 4'h9;
	localparam logic [MODE_W-1:0] MODE_SOFT_INT = 4'hA;
	localparam logic [MODE_W-1:0] MODE_AUTO_TRIG = 4'hB;
	localparam logic [VALUE_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [VALUE_W-1:0] COUNT_STEP = 16'h0001;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} value_pair_s;

	typedef struct packed {
		logic matchFlag;
		logic pinLevel;
		logic conversionStart;
		logic timerClear;
	} compare_out_s;
endpackage

// ---- tick_sync.sv ----
// Purpose: three-stage synchroniser with edge report
// Assumes: input is asynchronous to ref_clk
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ps
module tick_sync
	import ccp_compare_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic asyncIn,
	output logic rise
);
	logic [SYNC_W-1:0] stage;
	logic settled;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage <= '0;
		end else begin
			stage <= {stage[SYNC_W-2:0], asyncIn};
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			settled <= 1'b0;
			rise <= 1'b0;
		end else begin
			rise <= 1'b0;
			if (stage[1] == stage[2] && stage[2] != settled) begin
				settled <= stage[2];
				rise <= stage[2];
			end
		end
	end
endmodule

// ---- ccp_compare_unit.sv ----
// Purpose: compare half of the capture/compare unit with its shared timer
// Assumes: timer clock arrives as a pin (instruction clock or external)
// Notes: all control is by plain ports; outputs are registered
`timescale 1ns/1ps
module ccp_compare_unit
	import ccp_compare_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic timerClockPin,
	input wire logic timerEnable,
	input wire logic sleepActive,
	input wire logic externalClockSel,
	input wire logic [MODE_W-1:0] compare_mode_select,
	input wire value_pair_s compareValue,
	input wire logic compareWrite,
	input wire logic flagClear,
	input wire logic converterEnabled,
	output value_pair_s timerCount,
	output logic match_interrupt_flag,
	output logic compareOut,
	output logic compareOutEnable,
	output logic conversionTrigger
);
	////////////////////////////////////////////////////////////////////////////////
	// Timer tick from the pin
	logic tick;
	logic clearPending;
	logic counting;
	logic matchNow;
	logic pinMode;

	tick_sync tickSync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.asyncIn(timerClockPin),
		.rise(tick)
	);

	// Instruction clock stops in sleep; external source keeps running
	assign counting = timerEnable && tick && (externalClockSel || !sleepActive);

	// Equality checked once per timer edge
	assign matchNow = counting && (timerCount == compareValue);

	assign pinMode = (compare_mode_select == MODE_TOGGLE) || (compare_mode_select == MODE_SET)
		|| (compare_mode_select == MODE_CLEAR);

	////////////////////////////////////////////////////////////////////////////////
	// Shared timer
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timerCount <= COUNT_RESET;
		end else if (counting) begin
			if (clearPending) begin
				timerCount <= COUNT_RESET;
			end else begin
				timerCount <= timerCount + COUNT_STEP;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			clearPending <= 1'b0;
		end else if (matchNow && compare_mode_select == MODE_AUTO_TRIG) begin
			clearPending <= 1'b1;
		end else if (counting) begin
			clearPending <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Match actions
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			match_interrupt_flag <= 1'b0;
		end else if (matchNow && compare_mode_select != MODE_OFF) begin
			match_interrupt_flag <= 1'b1;
		end else if (flagClear) begin
			match_interrupt_flag <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			compareOut <= 1'b0;
		end else if (compare_mode_select == MODE_OFF) begin
			compareOut <= 1'b0;
		end else if (matchNow) begin
			unique case (compare_mode_select)
				MODE_TOGGLE: compareOut <= !compareOut;
				MODE_SET: compareOut <= 1'b1;
				MODE_CLEAR: compareOut <= 1'b0;
				default: compareOut <= compareOut;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			compareOutEnable <= 1'b0;
		end else begin
			compareOutEnable <= pinMode;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			conversionTrigger <= 1'b0;
		end else begin
			conversionTrigger <= matchNow && converterEnabled
				&& compare_mode_select == MODE_AUTO_TRIG;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence autoMatch_q;
		matchNow && compare_mode_select == MODE_AUTO_TRIG;
	endsequence

	// Remembers an auto-trigger match until the timer's next tick
	logic clearWatch;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			clearWatch <= 1'b0;
		end else if (matchNow && compare_mode_select == MODE_AUTO_TRIG) begin
			clearWatch <= 1'b1;
		end else if (counting) begin
			clearWatch <= 1'b0;
		end
	end

	sequence nextTickClears_q;
		counting ##1 timerCount == COUNT_RESET;
	endsequence

	sequence plainTick_q;
		counting && !clearWatch;
	endsequence

	sequence stepsOne_q;
		timerCount == $past(timerCount) + COUNT_STEP;
	endsequence

	flag_on_match_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		matchNow && compare_mode_select != MODE_OFF |=> match_interrupt_flag)
		else $error("match did not set flag");

	flag_holds_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		match_interrupt_flag && !flagClear |=> match_interrupt_flag)
		else $error("flag dropped without clear");

	soft_int_pin_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		matchNow && compare_mode_select == MODE_SOFT_INT |=> $stable(compareOut))
		else $error("software interrupt mode moved pin");

	auto_trig_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		autoMatch_q and converterEnabled |=> conversionTrigger)
		else $error("no conversion trigger");

	timer_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clearWatch && counting |-> nextTickClears_q)
		else $error("timer not cleared on next tick");

	trigger_only_match_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		conversionTrigger |-> $past(matchNow))
		else $error("trigger without match");

	off_forces_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		compare_mode_select == MODE_OFF |=> !compareOut)
		else $error("output latch not low when off");

	toggle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		matchNow && compare_mode_select == MODE_TOGGLE |=> compareOut != $past(compareOut))
		else $error("toggle did not toggle");

	sleep_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sleepActive && !externalClockSel |=> $stable(timerCount))
		else $error("timer moved in sleep");

	single_eval_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		matchNow |=> !matchNow)
		else $error("match seen twice");

	equal_sets_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		counting && timerCount == compareValue && compare_mode_select != MODE_OFF
		|=> match_interrupt_flag)
		else $error("equal count on a tick did not set flag");

	flag_cause_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!match_interrupt_flag && !(matchNow && compare_mode_select != MODE_OFF)
		|=> !match_interrupt_flag)
		else $error("flag set without a match");

	set_pin_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		matchNow && compare_mode_select == MODE_SET |=> compareOut)
		else $error("set mode did not raise output");

	clear_pin_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		matchNow && compare_mode_select == MODE_CLEAR |=> !compareOut)
		else $error("clear mode did not lower output");

	auto_pin_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		autoMatch_q |=> $stable(compareOut))
		else $error("auto trigger mode moved pin");

	pin_enable_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		compare_mode_select == MODE_SOFT_INT || compare_mode_select == MODE_AUTO_TRIG
		|=> !compareOutEnable)
		else $error("pin driven in a no-pin mode");

	trig_needs_adc_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		conversionTrigger |-> $past(converterEnabled)
		&& $past(compare_mode_select) == MODE_AUTO_TRIG)
		else $error("trigger without enabled converter");

	trig_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		conversionTrigger |=> !conversionTrigger)
		else $error("trigger longer than one cycle");

	count_step_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		plainTick_q |=> stepsOne_q)
		else $error("timer did not step once on a tick");

	sleep_ext_count_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sleepActive && externalClockSel && timerEnable && tick && !clearWatch |=> stepsOne_q)
		else $error("external timer stopped in sleep");
endmodule

// ---- timer_tick_source.sv ----
// Purpose: far-side timer clock source
// Assumes: ticks run from a divided or external clock
// Notes: pin rests low between bursts
`timescale 1ns/1ps
module timer_tick_source (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [3:0] nTicks,
	output logic timerClockPin,
	output logic busy
);
	logic [3:0] left;
	logic [2:0] phase;
	assign busy = (left != 4'h0);
	// Synchronous ticks, high 4 and low 4 cycles
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			left <= 4'h0;
			phase <= 3'h0;
			timerClockPin <= 1'b0;
		end else if (start && !busy) begin
			left <= nTicks;
			phase <= 3'h0;
		end else if (busy) begin
			phase <= phase + 3'h1;
			timerClockPin <= (phase < 3'h4);
			if (phase == 3'h7)
				left <= left - 4'h1;
		end
	end
endmodule

// ---- tb_ccp_compare_unit.sv ----
// Purpose: self-checking bench for the compare unit
// Assumes: 200 MHz ref_clk
// Notes: compareWrite tied low
`timescale 1ns/1ps
module tb_ccp_compare_unit;
	import ccp_compare_pkg::*;
	logic ref_clk = 0, reset_n = 0, timerEnable = 1, sleepActive = 0, extSel = 0;
	logic [MODE_W-1:0] mode = MODE_OFF;
	value_pair_s cmpVal = '0;
	logic flagClear = 0, convEn = 0, start = 0, pin, busy, flag, out, outEn, trig;
	logic [3:0] nTicks = 4'h0;
	value_pair_s cnt;
	logic [15:0] expCnt = 16'h0000;
	int fail_count = 0, n_tests = 0, trigN = 0;
	////////////////////////////////////////////////////////////////
	ccp_compare_unit u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .timerClockPin(pin),
		.timerEnable(timerEnable), .sleepActive(sleepActive), .externalClockSel(extSel),
		.compare_mode_select(mode), .compareValue(cmpVal), .compareWrite(1'b0),
		.flagClear(flagClear), .converterEnabled(convEn), .timerCount(cnt),
		.match_interrupt_flag(flag), .compareOut(out), .compareOutEnable(outEn),
		.conversionTrigger(trig));
	timer_tick_source u_src (.ref_clk(ref_clk), .reset_n(reset_n), .start(start),
		.nTicks(nTicks), .timerClockPin(pin), .busy(busy));
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (trig === 1'b1)
			trigN++;
	end
	////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (fail_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input logic [3:0] n);
		int i;
		@(posedge ref_clk) start <= 1'b1;
		nTicks <= n;
		@(posedge ref_clk) start <= 1'b0;
		#1;
		for (i = 0; i < 300 && busy; i++)
			@(posedge ref_clk);
		if (busy) begin
			fail_count++;
			give_verdict();
		end
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic hit(input logic [MODE_W-1:0] m, input logic [15:0] v);
		@(posedge ref_clk) mode <= m;
		cmpVal <= v;
		flagClear <= 1'b1;
		@(posedge ref_clk) flagClear <= 1'b0;
		tick(4'h1);
		expCnt = expCnt + 16'h1;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		tick(4'h3);
		expCnt = 16'h3;
		chk(cnt, expCnt);
		hit(MODE_SET, expCnt);
		chk(out, 1);
		chk(flag, 1);
		chk(outEn, 1);
		chk(cnt, expCnt);
		hit(MODE_TOGGLE, expCnt);
		chk(out, 0);
		hit(MODE_TOGGLE, expCnt);
		chk(out, 1);
		hit(MODE_SOFT_INT, expCnt);
		chk({out, flag}, 2'b11);
		chk(outEn, 0);
		hit(MODE_SOFT_INT, expCnt + 16'h5);
		chk(flag, 0);
		hit(MODE_CLEAR, expCnt);
		chk({out, flag}, 2'b01);
		hit(MODE_SET, expCnt);
		@(posedge ref_clk) mode <= MODE_OFF;
		repeat (3) @(posedge ref_clk);
		#1 chk(out, 0);
		@(posedge ref_clk) convEn <= 1'b1;
		trigN = 0;
		hit(MODE_AUTO_TRIG, expCnt);
		chk({trigN[3:0], out}, 5'h2);
		chk(outEn, 0);
		tick(4'h1);
		chk(cnt, 0);
		hit(MODE_SOFT_INT, 16'hFFFF);
		chk(trigN, 1);
		@(posedge ref_clk) sleepActive <= 1'b1;
		tick(4'h2);
		chk(cnt, 1);
		@(posedge ref_clk) extSel <= 1'b1;
		tick(4'h1);
		chk(cnt, 2);
		@(posedge ref_clk) convEn <= 1'b0;
		hit(MODE_AUTO_TRIG, 16'h0002);
		chk(trigN, 1);
		tick(4'h1);
		chk(cnt, 0);
		@(posedge ref_clk) timerEnable <= 1'b0;
		tick(4'h1);
		chk(cnt, 0);
		give_verdict();
	end
endmodule
